// >>> common/rsf_pkg.sv
// Shared constants and types for the regulator sequencer and fault control
package rsf_pkg;
  localparam int NUM_OUT    = 6;   // Five bucks plus one boost
  localparam int NUM_BUCK   = 5;   // Bucks occupy channels 0..4
  localparam int BOOST_IDX  = 5;   // Boost channel index
  localparam int NUM_SLOTS  = 6;   // Power-up time slots
  localparam int SLOT_W     = 3;   // Slot code width, codes 6 and 7 mean no slot
  localparam int ILIM_W     = 4;   // Buck current-limit code width
  localparam int VCODE_W    = 6;   // Boost voltage code width
  localparam int DWELL_W    = 11;  // Ramp dwell in microseconds
  localparam int DWELL_CW   = 18;  // Dwell counter width in clock cycles
  localparam int SPACE_W    = 3;   // Slot spacing code width
  localparam int RDEL_W     = 5;   // Reset release delay code width
  localparam int CNT_W      = 32;  // Width of the long timers

  // Clock rates
  localparam int CLK_MHZ    = 100;
  localparam int CLK_HZ     = 100_000_000;
  localparam int MCLK_HZ    = 2_000_000;
  localparam int MCLK_DIV   = CLK_HZ / MCLK_HZ;

  // Times in their own units
  localparam int BOOST_T1_US    = 367;
  localparam int INIT_US        = 1500;
  localparam int SLOT_STEP_MS   = 1;
  localparam int RDEL_STEP_MS   = 5;
  localparam int LP_DEGLITCH_US = 100;
  localparam int PG_DEGLITCH_US = 50;

  // Derived cycle counts
  localparam int US_CYC          = CLK_MHZ;
  localparam int BOOST_T1_CYC    = BOOST_T1_US * CLK_MHZ;
  localparam int INIT_CYC        = INIT_US * CLK_MHZ;
  localparam int SLOT_STEP_CYC   = SLOT_STEP_MS * 1000 * CLK_MHZ;
  localparam int RDEL_STEP_CYC   = RDEL_STEP_MS * 1000 * CLK_MHZ;
  localparam int LP_DEGLITCH_CYC = LP_DEGLITCH_US * CLK_MHZ;
  localparam int PG_DEGLITCH_CYC = PG_DEGLITCH_US * CLK_MHZ;

  // Consecutive limited-cycle counts that trip a fault
  localparam logic [2:0] BUCK_OC_LAST  = 3'h7;  // Trip on the cycle after seven
  localparam logic [2:0] BOOST_OC_LAST = 3'h4;  // Trip on the fifth cycle
  localparam logic [2:0] DISC_OC_LAST  = 3'h3;  // Trip on the fourth master tick
  localparam logic [VCODE_W-1:0] VCODE_MIN  = 6'h00;  // 1.4 V start of the boost ramp
  localparam logic [VCODE_W-1:0] VCODE_STEP = 6'h01;  // One 200 mV step

  // Start-up sequencer states
  typedef enum logic [2:0] {SQ_IDLE, SQ_INIT, SQ_SLOT, SQ_WAIT, SQ_GAP, SQ_DONE, SQ_HALT}
    rsf_seq_t;
endpackage

// >>> core/rsf_top.sv
// Regulator start-up sequencer, boost stepping, fault latching and good output
`timescale 1ns/1ps
// Function
// - Boost waits 367 us then ramps up
// - Boost target steps 200 mV per dwell
// - Ignore bit blanks boost good while ramping
// - Buck current limit from 4-bit code
// - Buck over seven limited cycles latches off
// - Overcurrent during start-up halts the sequence
// - Boost five limited cycles asserts held fault
// - Disconnect limit four ticks latches boost off
// - Global good rises after sequence, all good
// - Global good falls on dip, heat, supply, disable
// - Ignore bit masks that output's good fault
// - All ignored: good follows first rising output
// - Slot gap timer starts when slot good
// - Wait 1.5 ms init before first regulator
// - Six slots, any regulator in any slot
// - Slot gap 0 to 7 ms, 1 ms steps
// - Global enable starts the start-up sequence
// - Reset falls at once, rises after delay
// - Standby settings lower or switch off outputs
// - Standby by control bit or standby pin
// - Discharge disabled output only when selected
// - Pin rise exits standby after 100 us
// - Global good falling edge deglitched 50 us
module rsf_top #(
  parameter int BOOST_T1_CYC_P    = rsf_pkg::BOOST_T1_CYC,    // Boost start delay
  parameter int INIT_CYC_P        = rsf_pkg::INIT_CYC,        // Start-up initialisation
  parameter int SLOT_STEP_CYC_P   = rsf_pkg::SLOT_STEP_CYC,   // One slot spacing step
  parameter int RDEL_STEP_CYC_P   = rsf_pkg::RDEL_STEP_CYC,   // One reset delay step
  parameter int LP_DEGLITCH_CYC_P = rsf_pkg::LP_DEGLITCH_CYC, // Standby pin deglitch
  parameter int PG_DEGLITCH_CYC_P = rsf_pkg::PG_DEGLITCH_CYC  // Good output deglitch
) (
  input  wire logic                                       clk,
  input  wire logic                                       rst_n,
  input  wire logic                                       en_pin,
  input  wire logic                                       supply_above_low,
  input  wire logic                                       supply_above_high,
  input  wire logic                                       thermal_fault,
  input  wire logic                                       low_power_pin,
  input  wire logic                                       low_power_control_reg,
  input  wire logic [rsf_pkg::NUM_OUT-1:0]                reg_enable,
  input  wire logic [rsf_pkg::NUM_OUT-1:0]                fault_clear,
  input  wire logic [rsf_pkg::NUM_OUT-1:0]                good_ignore_bit,
  input  wire logic [rsf_pkg::NUM_OUT-1:0]                discharge_select,
  input  wire logic [rsf_pkg::NUM_OUT-1:0]                standby_off,
  input  wire logic [rsf_pkg::NUM_OUT*rsf_pkg::SLOT_W-1:0] slot_assign,
  input  wire logic [rsf_pkg::SPACE_W-1:0]                slot_spacing_delay,
  input  wire logic [rsf_pkg::RDEL_W-1:0]                 reset_release_delay,
  input  wire logic [rsf_pkg::VCODE_W-1:0]                boost_normal_code,
  input  wire logic [rsf_pkg::VCODE_W-1:0]                boost_standby_code,
  input  wire logic [rsf_pkg::DWELL_W-1:0]                ramp_dwell_us,
  input  wire logic [rsf_pkg::NUM_BUCK*rsf_pkg::ILIM_W-1:0] buck_ilim_code,
  input  wire logic [rsf_pkg::NUM_OUT-1:0]                out_above_good,
  input  wire logic [rsf_pkg::NUM_BUCK-1:0]               buck_ilimit,
  input  wire logic [rsf_pkg::NUM_BUCK-1:0]               buck_sw_cycle,
  input  wire logic                                       boost_ilimit,
  input  wire logic                                       boost_sw_cycle,
  input  wire logic                                       disc_ilimit,
  output logic      [rsf_pkg::NUM_OUT-1:0]                reg_on,
  output logic      [rsf_pkg::NUM_OUT-1:0]                discharge_on,
  output logic      [rsf_pkg::NUM_OUT-1:0]                output_good_flag,
  output logic      [rsf_pkg::NUM_OUT-1:0]                oc_fault,
  output logic      [rsf_pkg::NUM_BUCK*rsf_pkg::ILIM_W-1:0] buck_ilim_thr,
  output logic      [rsf_pkg::VCODE_W-1:0]                boost_code,
  output logic                                            boost_ramping,
  output logic                                            boost_duty_cut,
  output logic                                            boost_fault,
  output logic                                            disc_switch_on,
  output logic                                            global_output_good,
  output logic                                            reset_out,
  output logic                                            low_power_mode,
  output logic                                            seq_done,
  output logic                                            seq_halted
);
  import rsf_pkg::*;

  // Refuse counts the timers cannot serve
  if (BOOST_T1_CYC_P < 1 || INIT_CYC_P < 1 || SLOT_STEP_CYC_P < 1 || RDEL_STEP_CYC_P < 1 ||
      LP_DEGLITCH_CYC_P < 1 || PG_DEGLITCH_CYC_P < 1) begin : g_chk
    $error("rsf_top: cycle counts must be at least one");
  end

  logic             rst_meta;                // Reset synchroniser stages
  logic             rst_sync_n;
  logic [7:0]       mclk_cnt;                // Master clock divider
  logic             mclk_tick;               // 2 MHz enable pulse
  rsf_seq_t         seq_state;               // Start-up sequencer
  logic [2:0]       slot;                    // Current time slot
  logic [CNT_W-1:0] seq_tmr;                 // Init and slot gap timer
  logic             init_done;               // Initialisation wait served once
  logic [NUM_OUT-1:0] seq_en;                // Outputs released by the sequencer
  logic [NUM_OUT-1:0] in_slot;               // Outputs assigned to current slot
  logic [NUM_OUT-1:0] trip;                  // Overcurrent trip this cycle
  logic [NUM_OUT-1:0] next_reg_on;
  logic [NUM_OUT-1:0] ok;                    // Good or ignored, per output
  logic [2:0]       oc_cnt [NUM_OUT];        // Consecutive limited cycles
  logic [2:0]       bst_cnt;                 // Boost limited cycles
  logic             bst_hold;                // Held boost overload fault
  logic [CNT_W-1:0] t1_cnt;                  // Boost start delay counter
  logic             t1_done;
  logic [DWELL_CW-1:0] dwell_cnt;            // Boost step dwell counter
  logic [CNT_W-1:0] por_cnt;                 // Reset release counter
  logic [CNT_W-1:0] lp_cnt;                  // Standby pin deglitch counter
  logic             lp_prev;
  logic             pin_standby;
  logic [CNT_W-1:0] pg_cnt;                  // Good output low-time counter

  // Reset release through two flops; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Master clock enable, one pulse per 2 MHz period
  wire mclk_wrap = (mclk_cnt == 8'(MCLK_DIV - 1));
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mclk_cnt  <= 8'h00;
      mclk_tick <= 1'b0;
    end else begin
      mclk_cnt  <= mclk_wrap ? 8'h00 : mclk_cnt + 8'h01;
      mclk_tick <= mclk_wrap;
    end
  end

  // Per-output slot match, enable gating, discharge and overcurrent latch
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    assign in_slot[i] = (slot_assign[i*SLOT_W +: SLOT_W] == slot);
    // Standby may switch an output off; a latched fault or heat keeps it off
    assign next_reg_on[i] = seq_en[i] & reg_enable[i] & ~oc_fault[i] & ~trip[i] & en_pin &
                            ~thermal_fault & supply_above_low &
                            ~(low_power_mode & standby_off[i]);
    assign ok[i] = good_ignore_bit[i] | output_good_flag[i];
    // Bucks count switching cycles, the boost channel counts master ticks
    wire samp = (i < NUM_BUCK) ? buck_sw_cycle[i % NUM_BUCK] : mclk_tick;
    wire lim  = (i < NUM_BUCK) ? buck_ilimit[i % NUM_BUCK] & reg_on[i] : disc_ilimit;
    wire [2:0] last = (i < NUM_BUCK) ? BUCK_OC_LAST : DISC_OC_LAST;
    assign trip[i] = samp & lim & (oc_cnt[i] == last);
    always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        oc_cnt[i]           <= 3'h0;
        oc_fault[i]         <= 1'b0;
        output_good_flag[i] <= 1'b0;
        discharge_on[i]     <= 1'b0;
      end else begin
        if (samp) begin
          oc_cnt[i] <= (lim && !trip[i]) ? oc_cnt[i] + 3'h1 : 3'h0;
        end
        // Trip wins over a clear in the same cycle
        if (trip[i]) begin
          oc_fault[i] <= 1'b1;
        end else if (fault_clear[i]) begin
          oc_fault[i] <= 1'b0;
        end
        output_good_flag[i] <= next_reg_on[i] & out_above_good[i];
        discharge_on[i]     <= ~next_reg_on[i] & discharge_select[i];
      end
    end
  end

  // Registered copies of outputs that have no logic of their own
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_on         <= '0;
      buck_ilim_thr  <= '0;
      boost_duty_cut <= 1'b0;
      disc_switch_on <= 1'b0;
      boost_fault    <= 1'b0;
    end else begin
      reg_on         <= next_reg_on;
      buck_ilim_thr  <= buck_ilim_code;
      boost_duty_cut <= boost_ilimit & reg_on[BOOST_IDX];
      disc_switch_on <= next_reg_on[BOOST_IDX];
      boost_fault    <= bst_hold | oc_fault[BOOST_IDX] | trip[BOOST_IDX];
    end
  end

  // Boost overload count; the fault holds until the boost is powered off
  wire bst_trip = boost_sw_cycle & boost_ilimit & reg_on[BOOST_IDX] & (bst_cnt == BOOST_OC_LAST);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bst_cnt  <= 3'h0;
      bst_hold <= 1'b0;
    end else if (!reg_on[BOOST_IDX]) begin
      bst_cnt  <= 3'h0;
      bst_hold <= 1'b0;
    end else begin
      if (boost_sw_cycle) begin
        bst_cnt <= (boost_ilimit && !bst_trip) ? bst_cnt + 3'h1 : 3'h0;
      end
      bst_hold <= bst_hold | bst_trip;
    end
  end

  // Boost soft start and stepped voltage control
  wire [VCODE_W-1:0]  bst_tgt   = low_power_mode ? boost_standby_code : boost_normal_code;
  wire [DWELL_CW-1:0] dwell_cyc = DWELL_CW'(ramp_dwell_us) * DWELL_CW'(US_CYC);
  wire dwell_end = (dwell_cnt + DWELL_CW'(1) >= dwell_cyc);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      t1_cnt        <= '0;
      t1_done       <= 1'b0;
      dwell_cnt     <= '0;
      boost_code    <= VCODE_MIN;
      boost_ramping <= 1'b0;
    end else if (!reg_on[BOOST_IDX]) begin
      t1_cnt        <= '0;
      t1_done       <= 1'b0;
      dwell_cnt     <= '0;
      boost_code    <= VCODE_MIN;
      boost_ramping <= 1'b0;
    end else if (!t1_done) begin
      t1_cnt        <= t1_cnt + 32'h1;
      t1_done       <= (t1_cnt >= 32'(BOOST_T1_CYC_P - 1));
      boost_ramping <= 1'b1;
    end else if (boost_code != bst_tgt) begin
      boost_ramping <= 1'b1;
      dwell_cnt     <= dwell_end ? '0 : dwell_cnt + DWELL_CW'(1);
      // One step per dwell, either direction
      if (dwell_end) begin
        boost_code <= (bst_tgt > boost_code) ? boost_code + VCODE_STEP
                                             : boost_code - VCODE_STEP;
      end
    end else begin
      dwell_cnt     <= '0;
      boost_ramping <= 1'b0;
    end
  end

  // Start-up sequencer over six slots
  wire slot_good = &(~in_slot | output_good_flag);
  wire any_trip  = |(trip | oc_fault);
  wire [CNT_W-1:0] gap_cyc = CNT_W'(slot_spacing_delay) * CNT_W'(SLOT_STEP_CYC_P);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq_state <= SQ_IDLE;
      slot      <= 3'h0;
      seq_tmr   <= '0;
      seq_en    <= '0;
      init_done <= 1'b0;
    end else if (!en_pin) begin
      seq_state <= SQ_IDLE;
      slot      <= 3'h0;
      seq_tmr   <= '0;
      seq_en    <= '0;
    end else begin
      case (seq_state)
        SQ_IDLE: begin
          // Enable high starts the sequence once the supply is up
          if (supply_above_low) begin
            seq_state <= init_done ? SQ_SLOT : SQ_INIT;
          end
        end
        SQ_INIT: begin
          seq_tmr <= seq_tmr + 32'h1;
          if (seq_tmr >= 32'(INIT_CYC_P - 1)) begin
            seq_state <= SQ_SLOT;
            seq_tmr   <= '0;
            init_done <= 1'b1;
          end
        end
        SQ_SLOT: begin
          seq_en    <= seq_en | in_slot;
          seq_state <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (any_trip) begin
            seq_state <= SQ_HALT;
          end else if (slot_good) begin
            seq_state <= (slot == 3'(NUM_SLOTS - 1)) ? SQ_DONE : SQ_GAP;
            seq_tmr   <= '0;
          end
        end
        SQ_GAP: begin
          seq_tmr <= seq_tmr + 32'h1;
          if (any_trip) begin
            seq_state <= SQ_HALT;
          end else if (seq_tmr >= gap_cyc) begin
            seq_state <= SQ_SLOT;
            slot      <= slot + 3'h1;
          end
        end
        SQ_DONE: seq_state <= SQ_DONE;
        SQ_HALT: seq_state <= SQ_HALT;
        default: seq_state <= SQ_IDLE;
      endcase
    end
  end

  // Global good: done sequence, every output good or ignored, deglitched fall
  wire all_ignore = &good_ignore_bit;
  wire pg_raw = (seq_state == SQ_DONE || (all_ignore && |reg_on)) && (&ok) &&
                !thermal_fault && supply_above_low;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pg_cnt             <= '0;
      global_output_good <= 1'b0;
      seq_done           <= 1'b0;
      seq_halted         <= 1'b0;
    end else begin
      seq_done   <= (seq_state == SQ_DONE);
      seq_halted <= (seq_state == SQ_HALT);
      if (pg_raw) begin
        pg_cnt             <= '0;
        global_output_good <= 1'b1;
      end else begin
        pg_cnt <= pg_cnt + 32'h1;
        if (pg_cnt >= 32'(PG_DEGLITCH_CYC_P - 1)) begin
          global_output_good <= 1'b0;
        end
      end
    end
  end

  // Reset output: immediate fall, delayed rise above the upper threshold
  wire [CNT_W-1:0] rdel_cyc = (CNT_W'(reset_release_delay) + 32'h1) * CNT_W'(RDEL_STEP_CYC_P);
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      por_cnt   <= '0;
      reset_out <= 1'b0;
    end else if (!supply_above_low) begin
      por_cnt   <= '0;
      reset_out <= 1'b0;
    end else if (supply_above_high && !reset_out) begin
      por_cnt <= por_cnt + 32'h1;
      if (por_cnt >= rdel_cyc - 32'h1) begin
        reset_out <= 1'b1;
      end
    end
  end

  // Standby entry by pin fall or control bit; pin rise exits after deglitch
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lp_prev        <= 1'b1;
      pin_standby    <= 1'b0;
      lp_cnt         <= '0;
      low_power_mode <= 1'b0;
    end else begin
      lp_prev        <= low_power_pin;
      low_power_mode <= low_power_control_reg | pin_standby;
      if (lp_prev && !low_power_pin) begin
        pin_standby <= 1'b1;
        lp_cnt      <= '0;
      end else if (!low_power_pin) begin
        lp_cnt <= '0;
      end else if (pin_standby) begin
        lp_cnt <= lp_cnt + 32'h1;
        if (lp_cnt >= 32'(LP_DEGLITCH_CYC_P - 1)) begin
          pin_standby <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  AST_BUCK_TRIP: assert property (
    (buck_sw_cycle[0] && buck_ilimit[0] && reg_on[0] && oc_cnt[0] == 3'h7)
      |=> oc_fault[0] ##1 !reg_on[0]) else $error("buck fault not latched");
  AST_OC_OFF: assert property (
    oc_fault[0] |=> !reg_on[0]) else $error("faulted output still on");
  AST_BOOST_HOLD: assert property (
    (bst_trip && reg_on[BOOST_IDX]) |=> ##1 boost_fault) else $error("boost fault missing");
  AST_DISC_TRIP: assert property (
    (mclk_tick && disc_ilimit && oc_cnt[BOOST_IDX] == 3'h3)
      |=> oc_fault[BOOST_IDX] ##1 !reg_on[BOOST_IDX]) else $error("disconnect not latched");
  AST_HALT_FREEZE: assert property (
    (seq_state == SQ_HALT && en_pin) |=> $stable(seq_en)) else $error("halt enabled output");
  AST_PG_RISE: assert property (
    $rose(global_output_good) |-> $past(pg_raw)) else $error("good rose without cause");
  AST_PG_GLITCH: assert property (
    (global_output_good && $fell(pg_raw)) |-> global_output_good[*8])
    else $error("good fell inside deglitch");
  AST_RESET_FALL: assert property (
    !supply_above_low |=> !reset_out) else $error("reset not dropped");
  AST_DISCHARGE: assert property (
    discharge_on[2] |-> (!reg_on[2] && $past(discharge_select[2])))
    else $error("discharge on wrong output");
  AST_BOOST_STEP: assert property (
    (reg_on[BOOST_IDX] && $past(reg_on[BOOST_IDX]) && $changed(boost_code)) |->
      (boost_code == $past(boost_code) + VCODE_STEP ||
       boost_code == $past(boost_code) - VCODE_STEP))
    else $error("boost step not one code");
endmodule

// >>> sim/rsf_plant.sv
// Plant model: output comparators and switching cycles
`timescale 1ns/1ps
module rsf_plant (
  input  wire logic [5:0] reg_on,
  input  wire logic       clk,
  output logic      [5:0] out_above_good,
  output logic      [4:0] buck_sw_cycle,
  output logic            boost_sw_cycle
);
  logic [5:0] rise1 = 6'h00;  // First stage of output rise
  logic [5:0] rise2 = 6'h00;  // Second stage of output rise
  logic [1:0] phase = 2'h0;   // Switching phase
  initial out_above_good = 6'h00;
  // Good three cycles after enable; a disabled output reads low on the next clock
  always @(posedge clk) begin
    rise1 <= reg_on;
    rise2 <= rise1 & reg_on;
    out_above_good <= rise2 & reg_on;
    phase <= phase + 2'h1;
  end
  // One switching cycle every fourth clock, shared by all converters
  assign buck_sw_cycle  = {5{phase == 2'h3}};
  assign boost_sw_cycle = (phase == 2'h3);
endmodule

// >>> sim/rsf_top_tb.sv
// Self-checking bench for the regulator sequencer and fault control
`timescale 1ns/1ps
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module rsf_top_tb;
  import rsf_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, en_pin = 1'b0, thermal_fault = 1'b0;
  logic supply_above_low = 1'b1, supply_above_high = 1'b1, low_power_pin = 1'b1;
  logic low_power_control_reg = 1'b0, boost_ilimit = 1'b0, disc_ilimit = 1'b0;
  logic [5:0] reg_enable = 6'h3F, fault_clear = 6'h00, good_ignore_bit = 6'h00;
  logic [5:0] discharge_select = 6'h00, standby_off = 6'h00, boost_normal_code = 6'h00;
  logic [5:0] boost_standby_code = 6'h00, out_above_good, reg_on, discharge_on, oc_fault;
  logic [17:0] slot_assign = 18'h2C688;  // Output n sits in slot n
  logic [2:0]  slot_spacing_delay = 3'h1;
  logic [4:0]  reset_release_delay = 5'h00, buck_ilimit = 5'h00, buck_sw_cycle;
  logic [10:0] ramp_dwell_us = 11'h001;
  logic [19:0] buck_ilim_code = 20'h00000, buck_ilim_thr;
  logic boost_sw_cycle, global_output_good, reset_out, low_power_mode, seq_done;
  logic seq_halted, boost_ramping, boost_duty_cut, boost_fault, disc_switch_on;
  logic [5:0] output_good_flag, boost_code;
  int fail_count = 0, n_tests = 0;
  logic [31:0] rng = 32'h4034;            // Xorshift state
  typedef struct {int s; logic [31:0] e;} rsf_note_t;
  rsf_note_t notes[$];                    // Expected results, oldest first
  event chk_ev;
  rsf_top #(.BOOST_T1_CYC_P(20), .INIT_CYC_P(30), .SLOT_STEP_CYC_P(10),
    .RDEL_STEP_CYC_P(10), .LP_DEGLITCH_CYC_P(8), .PG_DEGLITCH_CYC_P(12)) rsf_top_inst (
    .clk, .rst_n, .en_pin, .supply_above_low, .supply_above_high, .thermal_fault,
    .low_power_pin, .low_power_control_reg, .reg_enable, .fault_clear, .good_ignore_bit,
    .discharge_select, .standby_off, .slot_assign, .slot_spacing_delay,
    .reset_release_delay, .boost_normal_code, .boost_standby_code, .ramp_dwell_us,
    .buck_ilim_code, .out_above_good, .buck_ilimit, .buck_sw_cycle, .boost_ilimit,
    .boost_sw_cycle, .disc_ilimit, .reg_on, .discharge_on, .output_good_flag,
    .oc_fault, .buck_ilim_thr, .boost_code, .boost_ramping, .boost_duty_cut,
    .boost_fault, .disc_switch_on, .global_output_good, .reset_out,
    .low_power_mode, .seq_done, .seq_halted);
  rsf_plant rsf_plant_inst (.reg_on, .clk, .out_above_good, .buck_sw_cycle, .boost_sw_cycle);
  always #5 clk = ~clk;
  // Output selected by a note
  function automatic logic [31:0] obs(int s);
    case (s)
      0: return 32'(seq_done);
      1: return 32'(reg_on);
      2: return 32'(global_output_good);
      3: return 32'(oc_fault);
      4: return 32'(discharge_on);
      5: return 32'(buck_ilim_thr);
      6: return 32'(low_power_mode);
      8: return 32'(boost_fault);
      9: return 32'(disc_switch_on);
      10: return 32'(boost_duty_cut);
      11: return 32'(output_good_flag);
      12: return 32'(boost_ramping);
      13: return 32'(boost_code);
      14: return 32'(seq_halted);
      default: return 32'(reset_out);
    endcase
  endfunction
  function automatic void nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
  endfunction
  // Driver side files an expectation and flags that a result is due
  task automatic note(int s, logic [31:0] e);
    notes.push_back('{s, e});
    -> chk_ev;
  endtask
  // Watcher checks every waiting note, oldest first, when a result is flagged
  always @(chk_ev) while (notes.size() > 0) begin
    `CMP(obs(notes[0].s), notes[0].e)
    void'(notes.pop_front());
  end
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_for(int s, logic [31:0] v, int lim);
    int i;
    for (i = 0; i < lim && obs(s) !== v; i++) @(negedge clk);
    if (i == lim) begin
      fail_count++;
      $display("MISMATCH t=%0t wait ran out on output %0d", $time, s);
      close_out();
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence: start-up, buck fault and recovery, standby, supply loss
  initial begin
    nxt();
    buck_ilim_code = rng[19:0];
    discharge_select = rng[25:20];
    nxt();
    boost_normal_code = rng[5:0] | 6'h01;
    ramp_dwell_us = 11'(rng[7:6]);
    reset_release_delay = rng[12:8];
    slot_spacing_delay = rng[15:13];
    cyc(12);
    rst_n = 1'b1;
    cyc(4);
    note(1, 32'h0);
    note(7, 32'h0);
    note(5, 32'(buck_ilim_code));
    wait_for(7, 32'h1, 400);
    en_pin = 1'b1;
    wait_for(0, 32'h1, 2000);
    note(1, 32'h3F);
    note(11, 32'h3F);
    note(12, 32'h1);
    cyc(2);
    note(2, 32'h1);
    wait_for(13, 32'(boost_normal_code), 20000);
    cyc(2);
    note(12, 32'h0);
    note(2, 32'h1);
    buck_ilimit = 5'h01;
    wait_for(3, 32'h1, 200);
    note(1, 32'h3E);
    cyc(3);
    note(2, 32'h1);
    cyc(16);
    note(2, 32'h0);
    buck_ilimit = 5'h00;
    reg_enable = 6'h3E;
    cyc(1);
    fault_clear = 6'h01;
    cyc(1);
    fault_clear = 6'h00;
    cyc(2);
    note(3, 32'h0);
    note(4, 32'(discharge_select[0]));
    reg_enable = 6'h3F;
    cyc(2);
    note(1, 32'h3F);
    boost_ilimit = 1'b1;
    cyc(1);
    note(10, 32'h1);
    wait_for(8, 32'h1, 40);
    boost_ilimit = 1'b0;
    cyc(8);
    note(8, 32'h1);
    note(1, 32'h3F);
    good_ignore_bit = 6'h20;
    disc_ilimit = 1'b1;
    wait_for(3, 32'h20, 300);
    note(9, 32'h0);
    note(1, 32'h1F);
    disc_ilimit = 1'b0;
    cyc(16);
    note(2, 32'h1);
    standby_off = 6'h02;
    low_power_control_reg = 1'b1;
    cyc(3);
    note(6, 32'h1);
    note(1, 32'h1D);
    note(4, 32'(discharge_select & 6'h22));
    low_power_control_reg = 1'b0;
    cyc(3);
    note(6, 32'h0);
    note(1, 32'h1F);
    low_power_pin = 1'b0;
    cyc(3);
    note(6, 32'h1);
    low_power_pin = 1'b1;
    cyc(4);
    note(6, 32'h1);
    cyc(8);
    note(6, 32'h0);
    en_pin = 1'b0;
    cyc(2);
    en_pin = 1'b1;
    wait_for(14, 32'h1, 20);
    note(1, 32'h01);
    thermal_fault = 1'b1;
    cyc(3);
    note(1, 32'h0);
    supply_above_low = 1'b0;
    supply_above_high = 1'b0;
    cyc(2);
    note(7, 32'h0);
    supply_above_low = 1'b1;
    cyc(20);
    note(7, 32'h0);
    supply_above_high = 1'b1;
    cyc(5);
    note(7, 32'h0);
    wait_for(7, 32'h1, 400);
    cyc(2);
    close_out();
  end
endmodule
